/* File: design/hpm_cfg.svh */
// Holds the register offsets, field positions and reset values of the transfer engine.
// Assumes byte addresses on the plain register port, each register one aligned word.
//
// Functional notes
// - Enable bits mask status onto interrupt output.
// - Source address loadable, advances with moved bytes.
// - Destination address loadable, advances with moved bytes.
// - Upper flags pick local or host per address.
// - Low count decrements; zero ends the transfer.
// - Nonzero count write launches; addresses set first.
// - Upper half encodes transfer type and options.
// - Burst timer loads at burst start, counts cycles.
// - Timer expiry: finish data phase, release bus.
// - Zero max burst time means unlimited bursts.
// - Storage requests never exceed the memory limit.
// - Checksum accumulates; software write seeds it.
// - Top checksum bit keeps persistent byte alignment.
// - Four checksum views: plain, inverted, swapped, both.
// - Read counter counts inbound, optionally descriptor bytes.
// - Write counter counts bytes moved outbound.
// - Sixty-four word staging array, diagnostic port.
// - Data port read returns word, bumps pointer.
// - Data port write stores word, bumps pointer.
// - Transfers wait for enabled receive or transmit.
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH

`define HPM_OFS_ISTS 8'h00
`define HPM_OFS_IEN 8'h04
`define HPM_OFS_CTRL 8'h08
`define HPM_OFS_SRC 8'h0C
`define HPM_OFS_DST 8'h10
`define HPM_OFS_CNTFLG 8'h14
`define HPM_OFS_MAXBURST 8'h18
`define HPM_OFS_MAXMEM 8'h1C
`define HPM_OFS_CSUM 8'h20
`define HPM_OFS_CSUM_INV 8'h24
`define HPM_OFS_CSUM_SWP 8'h28
`define HPM_OFS_CSUM_ISW 8'h2C
`define HPM_OFS_RDCNT 8'h30
`define HPM_OFS_WRCNT 8'h34
`define HPM_OFS_ARR_RA 8'h38
`define HPM_OFS_ARR_WA 8'h3C
`define HPM_OFS_ARR_DATA 8'h40

`define HPM_CTRL_RX_EN 0
`define HPM_CTRL_TX_EN 1
`define HPM_CTRL_CNT_DESC 2
`define HPM_FLG_SRC_LOCAL 16
`define HPM_FLG_DST_LOCAL 17
`define HPM_FLG_CSUM_EN 18
`define HPM_FLG_DESC 19
`define HPM_ISTS_DONE 0
`define HPM_CSUM_ALIGN 31

`define HPM_RST_WORD 32'h0000_0000
`define HPM_RST_CTRL 3'h0
`define HPM_RST_LIMIT 16'h0000
`define HPM_LIMIT_ZERO_AS 16'hFFFF
`define HPM_BEAT_BYTES 3'h4

`endif

/* File: design/hpm_pkg.sv */
// Holds the types shared by the transfer engine.
// Assumes the constants header is compiled alongside it.
package hpm_pkg;

	// Beat sequencer, Gray coded along idle, read, write, advance.
	typedef enum logic [1:0] {
		HPM_IDLE = 2'h0,
		HPM_RD = 2'h1,
		HPM_WR = 2'h3,
		HPM_NXT = 2'h2
	} hpm_state_type;

	typedef logic [31:0] hpm_word_type;
	typedef logic [15:0] hpm_half_type;

endpackage : hpm_pkg

/* File: design/hpm_dma.sv */
// Holds the general transfer engine: registers, beat sequencer, burst limiter, checksum, array.
// Assumes host bus and storage ports driven by logic on clk_sys_i; software uses the plain port.
`timescale 1ns/1ps
`include "hpm_cfg.svh"

module hpm_dma (
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire hpm_pkg::hpm_word_type reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output hpm_pkg::hpm_word_type reg_rdata_o,
	output logic irq_o,
	// Descriptor queue unit start port.
	input wire logic dq_start_i,
	input wire hpm_pkg::hpm_word_type dq_src_i,
	input wire hpm_pkg::hpm_word_type dq_dst_i,
	input wire hpm_pkg::hpm_word_type dq_cntflg_i,
	output logic dq_ready_o,
	// Host bus master side.
	output logic hst_req_o,
	input wire logic hst_gnt_i,
	output logic hst_valid_o,
	output logic hst_we_o,
	output hpm_pkg::hpm_word_type hst_addr_o,
	output hpm_pkg::hpm_word_type hst_wdata_o,
	input wire logic hst_ack_i,
	input wire hpm_pkg::hpm_word_type hst_rdata_i,
	// On-chip storage side.
	output logic mem_req_o,
	output logic mem_first_o,
	output hpm_pkg::hpm_half_type mem_len_o,
	output logic mem_we_o,
	output hpm_pkg::hpm_word_type mem_addr_o,
	output hpm_pkg::hpm_word_type mem_wdata_o,
	input wire logic mem_ack_i,
	input wire hpm_pkg::hpm_word_type mem_rdata_i
);
	import hpm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Checksum arithmetic.

	// Adds the first n bytes of a big-endian word; odd alignment places a byte low.
	function automatic hpm_word_type csum_add(input hpm_word_type c, input hpm_word_type d, input logic [2:0] n);
		logic [16:0] s;
		logic al;
		s = {1'b0, c[15:0]};
		al = c[`HPM_CSUM_ALIGN];
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < n) begin
				if (al) begin
					s = {1'b0, s[15:0]} + {9'h000, d[31 - 8 * i -: 8]};
				end else begin
					s = {1'b0, s[15:0]} + {1'b0, d[31 - 8 * i -: 8], 8'h00};
				end
				s = {1'b0, s[15:0]} + {16'h0000, s[16]};
				al = ~al;
			end
		end
		return {al, 15'h0000, s[15:0]};
	endfunction : csum_add

	////////////////////////////////////////////////////////////////////////////////
	// State and registers.

	hpm_state_type state_reg, state_next;
	logic [2:0] ctrl_reg;
	logic [0:0] ists_reg, ien_reg;
	hpm_word_type src_reg, dst_reg, cnt_reg, csum_reg, rdcnt_reg, wrcnt_reg, stage_reg;
	hpm_half_type maxb_reg, maxm_reg, bt_reg, chunk_reg;
	logic bact_reg, rel_reg;
	logic [5:0] ra_reg, wa_reg, sp_reg;
	hpm_word_type arr [0:63];

	// Decoded strobes of the register port and the queue start port.
	logic wr_cnt, wr_data, rd_data, launch_sw, launch_dq;
	assign wr_cnt = reg_wr_i && reg_addr_i == `HPM_OFS_CNTFLG;
	assign wr_data = reg_wr_i && reg_addr_i == `HPM_OFS_ARR_DATA;
	assign rd_data = reg_rd_i && reg_addr_i == `HPM_OFS_ARR_DATA;
	assign launch_sw = wr_cnt && reg_wdata_i[15:0] != 16'h0000 && state_reg == HPM_IDLE;
	assign launch_dq = dq_start_i && dq_ready_o && !launch_sw;
	assign dq_ready_o = state_reg == HPM_IDLE && cnt_reg[15:0] == 16'h0000;

	// Transfer flags, direction gate and per-beat size.
	logic src_loc, dst_loc, inbound, outbound, dir_ok, done_evt;
	logic [2:0] beat;
	hpm_half_type lim;
	assign src_loc = cnt_reg[`HPM_FLG_SRC_LOCAL];
	assign dst_loc = cnt_reg[`HPM_FLG_DST_LOCAL];
	assign inbound = dst_loc && !src_loc;
	assign outbound = src_loc && !dst_loc;
	assign dir_ok = inbound ? ctrl_reg[`HPM_CTRL_RX_EN] : outbound ? ctrl_reg[`HPM_CTRL_TX_EN]
		: (ctrl_reg[`HPM_CTRL_RX_EN] || ctrl_reg[`HPM_CTRL_TX_EN]);
	assign beat = cnt_reg[15:0] < 16'h0004 ? cnt_reg[2:0] : `HPM_BEAT_BYTES;
	assign lim = maxm_reg == 16'h0000 ? `HPM_LIMIT_ZERO_AS : maxm_reg;
	assign done_evt = state_reg == HPM_NXT && cnt_reg[15:0] == {13'h0000, beat};

	////////////////////////////////////////////////////////////////////////////////
	// Port sides for the current beat.

	logic host_beat, mem_beat, beat_ack, expired;
	assign host_beat = (state_reg == HPM_RD && !src_loc) || (state_reg == HPM_WR && !dst_loc);
	assign mem_beat = (state_reg == HPM_RD && src_loc) || (state_reg == HPM_WR && dst_loc);
	assign expired = bact_reg && maxb_reg != 16'h0000 && bt_reg == 16'h0000;
	assign hst_req_o = host_beat && !rel_reg;
	assign hst_valid_o = hst_req_o && hst_gnt_i;
	assign hst_we_o = state_reg == HPM_WR;
	assign hst_addr_o = state_reg == HPM_WR ? dst_reg : src_reg;
	assign hst_wdata_o = stage_reg;
	assign mem_req_o = mem_beat;
	assign mem_we_o = state_reg == HPM_WR;
	assign mem_addr_o = state_reg == HPM_WR ? dst_reg : src_reg;
	assign mem_wdata_o = stage_reg;
	assign mem_first_o = mem_beat && chunk_reg == 16'h0000;
	assign mem_len_o = cnt_reg[15:0] < lim ? cnt_reg[15:0] : lim;
	assign beat_ack = (hst_valid_o && hst_ack_i) || (mem_beat && mem_ack_i);

	////////////////////////////////////////////////////////////////////////////////
	// Beat sequencer: read a word, write it, then advance the counters.

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			HPM_IDLE: begin
				if (cnt_reg[15:0] != 16'h0000 && dir_ok) begin
					state_next = HPM_RD;
				end
			end
			HPM_RD: begin
				if (beat_ack) begin
					state_next = HPM_WR;
				end
			end
			HPM_WR: begin
				if (beat_ack) begin
					state_next = HPM_NXT;
				end
			end
			HPM_NXT: begin
				state_next = HPM_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_reg <= HPM_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Captures the source word of the beat.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			stage_reg <= `HPM_RST_WORD;
		end else if (state_reg == HPM_RD && beat_ack) begin
			stage_reg <= src_loc ? mem_rdata_i : hst_rdata_i;
		end
	end

	// Address registers load from software or the queue unit and advance per beat.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			src_reg <= `HPM_RST_WORD;
			dst_reg <= `HPM_RST_WORD;
		end else if (launch_dq) begin
			src_reg <= dq_src_i;
			dst_reg <= dq_dst_i;
		end else if (state_reg == HPM_NXT) begin
			src_reg <= src_reg + {29'h0000_0000, beat};
			dst_reg <= dst_reg + {29'h0000_0000, beat};
		end else if (reg_wr_i && state_reg == HPM_IDLE) begin
			if (reg_addr_i == `HPM_OFS_SRC) begin
				src_reg <= reg_wdata_i;
			end
			if (reg_addr_i == `HPM_OFS_DST) begin
				dst_reg <= reg_wdata_i;
			end
		end
	end

	// Count and flags: a launch loads them, each beat counts down.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt_reg <= `HPM_RST_WORD;
		end else if (launch_sw) begin
			cnt_reg <= reg_wdata_i;
		end else if (launch_dq) begin
			cnt_reg <= dq_cntflg_i;
		end else if (state_reg == HPM_NXT) begin
			cnt_reg[15:0] <= cnt_reg[15:0] - {13'h0000, beat};
		end else if (wr_cnt && state_reg == HPM_IDLE && cnt_reg[15:0] == 16'h0000) begin
			cnt_reg[31:16] <= reg_wdata_i[31:16];
		end
	end

	// Storage request splitting: a new request opens once the previous one is used up.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			chunk_reg <= 16'h0000;
		end else if (launch_sw || launch_dq) begin
			chunk_reg <= 16'h0000;
		end else if (mem_beat && mem_ack_i) begin
			chunk_reg <= (mem_first_o ? mem_len_o : chunk_reg) - {13'h0000, beat};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst limiter on the host bus.

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			bact_reg <= 1'b0;
			bt_reg <= 16'h0000;
			rel_reg <= 1'b0;
		end else begin
			rel_reg <= 1'b0;
			if (!hst_req_o) begin
				bact_reg <= 1'b0;
			end else if (hst_gnt_i && !bact_reg) begin
				bact_reg <= 1'b1;
				bt_reg <= maxb_reg;
			end else if (expired && hst_valid_o && hst_ack_i) begin
				bact_reg <= 1'b0;
				rel_reg <= 1'b1;
			end else if (bact_reg && bt_reg != 16'h0000) begin
				bt_reg <= bt_reg - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checksum and byte statistics.

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			csum_reg <= `HPM_RST_WORD;
		end else if (state_reg == HPM_NXT && cnt_reg[`HPM_FLG_CSUM_EN]) begin
			csum_reg <= csum_add(csum_reg, stage_reg, beat);
		end else if (reg_wr_i && reg_addr_i == `HPM_OFS_CSUM) begin
			csum_reg <= {reg_wdata_i[31], 15'h0000, reg_wdata_i[15:0]};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdcnt_reg <= `HPM_RST_WORD;
			wrcnt_reg <= `HPM_RST_WORD;
		end else if (state_reg == HPM_NXT) begin
			if (inbound && (!cnt_reg[`HPM_FLG_DESC] || ctrl_reg[`HPM_CTRL_CNT_DESC])) begin
				rdcnt_reg <= rdcnt_reg + {29'h0000_0000, beat};
			end
			if (outbound) begin
				wrcnt_reg <= wrcnt_reg + {29'h0000_0000, beat};
			end
		end else if (reg_wr_i) begin
			if (reg_addr_i == `HPM_OFS_RDCNT) begin
				rdcnt_reg <= reg_wdata_i;
			end
			if (reg_addr_i == `HPM_OFS_WRCNT) begin
				wrcnt_reg <= reg_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control, limits and interrupt status.

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_reg <= `HPM_RST_CTRL;
			ien_reg <= 1'b0;
			maxb_reg <= `HPM_RST_LIMIT;
			maxm_reg <= `HPM_RST_LIMIT;
		end else if (reg_wr_i) begin
			if (reg_addr_i == `HPM_OFS_CTRL) begin
				ctrl_reg <= reg_wdata_i[2:0];
			end
			if (reg_addr_i == `HPM_OFS_IEN) begin
				ien_reg <= reg_wdata_i[0];
			end
			if (reg_addr_i == `HPM_OFS_MAXBURST) begin
				maxb_reg <= reg_wdata_i[15:0];
			end
			if (reg_addr_i == `HPM_OFS_MAXMEM) begin
				maxm_reg <= reg_wdata_i[15:0];
			end
		end
	end

	// Done is sticky; writing one clears it, a new done in the same cycle wins.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ists_reg <= 1'b0;
		end else if (done_evt) begin
			ists_reg <= 1'b1;
		end else if (reg_wr_i && reg_addr_i == `HPM_OFS_ISTS && reg_wdata_i[`HPM_ISTS_DONE]) begin
			ists_reg <= 1'b0;
		end
	end

	assign irq_o = |(ists_reg & ien_reg);

	////////////////////////////////////////////////////////////////////////////////
	// Staging array and its diagnostic pointers.

	always_ff @(posedge clk_sys_i) begin
		if (wr_data) begin
			arr[wa_reg] <= reg_wdata_i;
		end else if (state_reg == HPM_RD && beat_ack) begin
			arr[sp_reg] <= src_loc ? mem_rdata_i : hst_rdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ra_reg <= 6'h00;
			wa_reg <= 6'h00;
			sp_reg <= 6'h00;
		end else begin
			if (state_reg == HPM_NXT) begin
				sp_reg <= sp_reg + 6'h01;
			end
			if (rd_data) begin
				ra_reg <= ra_reg + 6'h01;
			end else if (reg_wr_i && reg_addr_i == `HPM_OFS_ARR_RA) begin
				ra_reg <= reg_wdata_i[5:0];
			end
			if (wr_data) begin
				wa_reg <= wa_reg + 6'h01;
			end else if (reg_wr_i && reg_addr_i == `HPM_OFS_ARR_WA) begin
				wa_reg <= reg_wdata_i[5:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe; unmapped addresses read zero.

	hpm_word_type rd_mux;
	always_comb begin
		rd_mux = `HPM_RST_WORD;
		unique case (reg_addr_i)
			`HPM_OFS_ISTS: rd_mux = {31'h0000_0000, ists_reg};
			`HPM_OFS_IEN: rd_mux = {31'h0000_0000, ien_reg};
			`HPM_OFS_CTRL: rd_mux = {29'h0000_0000, ctrl_reg};
			`HPM_OFS_SRC: rd_mux = src_reg;
			`HPM_OFS_DST: rd_mux = dst_reg;
			`HPM_OFS_CNTFLG: rd_mux = cnt_reg;
			`HPM_OFS_MAXBURST: rd_mux = {16'h0000, maxb_reg};
			`HPM_OFS_MAXMEM: rd_mux = {16'h0000, maxm_reg};
			`HPM_OFS_CSUM: rd_mux = csum_reg;
			`HPM_OFS_CSUM_INV: rd_mux = {csum_reg[31:16], ~csum_reg[15:0]};
			`HPM_OFS_CSUM_SWP: rd_mux = {csum_reg[31:16], csum_reg[7:0], csum_reg[15:8]};
			`HPM_OFS_CSUM_ISW: rd_mux = {csum_reg[31:16], ~csum_reg[7:0], ~csum_reg[15:8]};
			`HPM_OFS_RDCNT: rd_mux = rdcnt_reg;
			`HPM_OFS_WRCNT: rd_mux = wrcnt_reg;
			`HPM_OFS_ARR_RA: rd_mux = {26'h000_0000, ra_reg};
			`HPM_OFS_ARR_WA: rd_mux = {26'h000_0000, wa_reg};
			`HPM_OFS_ARR_DATA: rd_mux = arr[ra_reg];
			default: rd_mux = `HPM_RST_WORD;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= `HPM_RST_WORD;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_expire_ack;
		expired && hst_valid_o && hst_ack_i;
	endsequence

	sequence s_released;
		!hst_req_o ##1 $stable(state_reg);
	endsequence

	a_irq_mask: assert property (ists_reg[0] && ien_reg[0] |-> irq_o) else $error("masked done lost");
	a_src_adv: assert property (state_reg == HPM_NXT |=> src_reg == $past(src_reg) + 32'($past(beat)))
		else $error("source not advanced");
	a_dst_adv: assert property (state_reg == HPM_NXT |=> dst_reg == $past(dst_reg) + 32'($past(beat)))
		else $error("destination not advanced");
	a_cnt_down: assert property (state_reg == HPM_NXT |=>
		cnt_reg[15:0] == $past(cnt_reg[15:0]) - 16'($past(beat))) else $error("count not decremented");
	a_launch_go: assert property (launch_sw && ctrl_reg == 3'h3 ##1 !reg_wr_i |=> state_reg == HPM_RD)
		else $error("launch did not start");
	a_burst_rel: assert property (s_expire_ack |=> s_released) else $error("bus not released");
	a_burst_unl: assert property (maxb_reg == 16'h0000 |=> !rel_reg) else $error("zero limit released");
	a_mem_limit: assert property (mem_first_o |-> mem_len_o <= lim && mem_len_o != 16'h0000)
		else $error("storage request too long");
	a_done_set: assert property (done_evt |=> ists_reg[0] && cnt_reg[15:0] == 16'h0000)
		else $error("done not flagged");
	a_arr_rd_inc: assert property (rd_data |=> ra_reg == $past(ra_reg) + 6'h01) else $error("read pointer stuck");
	a_dir_gate: assert property (state_reg == HPM_IDLE && !dir_ok |=> state_reg == HPM_IDLE)
		else $error("disabled direction ran");

endmodule : hpm_dma

/* File: dv/hpm_far_model.sv */
// Holds the far-side model: host memory behind a bus grant, and on-chip storage.
// Assumes the engine's host and storage ports on the same clock; slow_i stretches every acknowledge, not the grant.
`timescale 1ns/1ps

module hpm_far_model (
	// Clock, reset and pacing.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	// Host bus.
	input wire logic hst_req_i,
	input wire logic hst_valid_i,
	input wire logic hst_we_i,
	input wire hpm_pkg::hpm_word_type hst_addr_i,
	input wire hpm_pkg::hpm_word_type hst_wdata_i,
	output logic hst_gnt_o,
	output logic hst_ack_o,
	output hpm_pkg::hpm_word_type hst_rdata_o,
	// On-chip storage.
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire hpm_pkg::hpm_word_type mem_addr_i,
	input wire hpm_pkg::hpm_word_type mem_wdata_i,
	output logic mem_ack_o,
	output hpm_pkg::hpm_word_type mem_rdata_o
);
	import hpm_pkg::*;
	hpm_word_type hst_mem [64];
	hpm_word_type loc_mem [64];
	logic [2:0] hst_wait_reg;
	logic [2:0] mem_wait_reg;
	logic [2:0] delay;

	// Read data stand only beside the acknowledge; at other times the inverse shows.
	assign delay = slow_i ? 3'h3 : 3'h0;
	assign hst_rdata_o = hst_ack_o ? hst_mem[hst_addr_i[7:2]] : ~hst_mem[hst_addr_i[7:2]];
	assign mem_rdata_o = mem_ack_o ? loc_mem[mem_addr_i[7:2]] : ~loc_mem[mem_addr_i[7:2]];

	////////////////////////////////////////////////////////////////////////////////
	// Grant follows the request one cycle later and drops one cycle after the request drops.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hst_gnt_o <= 1'b0;
		end else begin
			hst_gnt_o <= hst_req_i;
		end
	end

	// Host memory space only answers; each data phase is acknowledged once, after the delay.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hst_ack_o <= 1'b0;
			hst_wait_reg <= 3'h0;
			for (int i = 0; i < 64; i++) hst_mem[i] <= 32'hC0DE_0000 | i;
		end else begin
			hst_ack_o <= hst_valid_i && !hst_ack_o && (hst_wait_reg >= delay);
			hst_wait_reg <= (hst_valid_i && !hst_ack_o) ? hst_wait_reg + 3'h1 : 3'h0;
			if (hst_valid_i && hst_ack_o && hst_we_i) hst_mem[hst_addr_i[7:2]] <= hst_wdata_i;
		end
	end

	// Storage beats are acknowledged the same way, with no grant.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			mem_ack_o <= 1'b0;
			mem_wait_reg <= 3'h0;
			for (int i = 0; i < 64; i++) loc_mem[i] <= 32'h5A00_0000 | (i << 8);
		end else begin
			mem_ack_o <= mem_req_i && !mem_ack_o && (mem_wait_reg >= delay);
			mem_wait_reg <= (mem_req_i && !mem_ack_o) ? mem_wait_reg + 3'h1 : 3'h0;
			if (mem_req_i && mem_ack_o && mem_we_i) loc_mem[mem_addr_i[7:2]] <= mem_wdata_i;
		end
	end
endmodule : hpm_far_model

/* File: dv/test_host_packet_memory_dma.sv */
// Holds the self-checking bench of the transfer engine and its far-side model.
// Assumes the register offsets header and a 200 MHz clock with synchronous reset.
`timescale 1ns/1ps
`include "hpm_cfg.svh"

module test_host_packet_memory_dma;
	import hpm_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	hpm_word_type reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic dq_start_i = 1'b0;
	hpm_word_type dq_src_i = 32'h0;
	hpm_word_type dq_dst_i = 32'h0;
	hpm_word_type dq_cntflg_i = 32'h0;
	logic far_slow = 1'b0;
	hpm_word_type reg_rdata_o, hst_addr_o, hst_wdata_o, hst_rdata_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic irq_o, dq_ready_o, hst_req_o, hst_gnt_i, hst_valid_o, hst_we_o, hst_ack_i;
	logic mem_req_o, mem_first_o, mem_we_o, mem_ack_i;
	hpm_half_type mem_len_o;
	logic [15:0] lim = 16'hFFFF;
	int n_fail = 0;
	int checks_done = 0;
	int cycles = 0;
	int firsts = 0;
	hpm_word_type sum;

	always #2.5 clk_sys_i = ~clk_sys_i;

	hpm_dma hpm_dma_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.irq_o(irq_o), .dq_start_i(dq_start_i), .dq_src_i(dq_src_i), .dq_dst_i(dq_dst_i),
		.dq_cntflg_i(dq_cntflg_i), .dq_ready_o(dq_ready_o), .hst_req_o(hst_req_o), .hst_gnt_i(hst_gnt_i),
		.hst_valid_o(hst_valid_o), .hst_we_o(hst_we_o), .hst_addr_o(hst_addr_o), .hst_wdata_o(hst_wdata_o),
		.hst_ack_i(hst_ack_i), .hst_rdata_i(hst_rdata_i), .mem_req_o(mem_req_o), .mem_first_o(mem_first_o),
		.mem_len_o(mem_len_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
		.mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

	hpm_far_model hpm_far_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(far_slow),
		.hst_req_i(hst_req_o), .hst_valid_i(hst_valid_o), .hst_we_i(hst_we_o), .hst_addr_i(hst_addr_o),
		.hst_wdata_i(hst_wdata_o), .hst_gnt_o(hst_gnt_i), .hst_ack_o(hst_ack_i), .hst_rdata_o(hst_rdata_i),
		.mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input hpm_word_type got, input hpm_word_type exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input hpm_word_type d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input hpm_word_type exp);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		chk(reg_rdata_o, exp);
	endtask : rd

	// Waits, bounded, for the engine to return to idle with count zero.
	task automatic wait_done();
		int k;
		k = 0;
		repeat (3) @(posedge clk_sys_i);
		#1;
		while (dq_ready_o !== 1'b1 && k < 400) begin
			@(posedge clk_sys_i);
			#1;
			k++;
		end
		chk({31'h0, dq_ready_o}, 32'h1);
	endtask : wait_done

	// Mid-cycle monitor of storage requests, plus the hang limit.
	always @(negedge clk_sys_i) begin
		cycles++;
		if (mem_req_o && mem_first_o && mem_ack_i) begin
			firsts++;
			if (mem_len_o > lim) chk({16'h0, mem_len_o}, {16'h0, lim});
		end
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(`HPM_OFS_CNTFLG, 32'h0);
		rd(8'h80, 32'h0);
		// Data port writes and reads walk sequential words across the top of the array.
		wr(`HPM_OFS_ARR_WA, 32'h3E);
		for (int i = 0; i < 3; i++) wr(`HPM_OFS_ARR_DATA, 32'hA5A5_0000 + i);
		wr(`HPM_OFS_ARR_RA, 32'h3E);
		for (int i = 0; i < 3; i++) rd(`HPM_OFS_ARR_DATA, 32'hA5A5_0000 + i);
		// Host to storage, eight bytes, seeded checksum, burst limit off.
		wr(`HPM_OFS_IEN, 32'h1);
		wr(`HPM_OFS_CTRL, 32'h1);
		wr(`HPM_OFS_CSUM, 32'h1111);
		wr(`HPM_OFS_SRC, 32'h100);
		wr(`HPM_OFS_DST, 32'h40);
		wr(`HPM_OFS_CNTFLG, 32'h0006_0008);
		wait_done();
		rd(`HPM_OFS_SRC, 32'h108);
		rd(`HPM_OFS_DST, 32'h48);
		rd(`HPM_OFS_CNTFLG, 32'h0006_0000);
		chk(hpm_far_model_inst.loc_mem[17], 32'hC0DE_0001);
		sum = 32'h1111 + 32'hC0DE + 32'h0000 + 32'hC0DE + 32'h0001;
		sum = {16'h0, sum[15:0] + sum[31:16]};
		rd(`HPM_OFS_CSUM, sum);
		rd(`HPM_OFS_CSUM_INV, {16'h0, ~sum[15:0]});
		rd(`HPM_OFS_CSUM_SWP, {16'h0, sum[7:0], sum[15:8]});
		rd(`HPM_OFS_CSUM_ISW, {16'h0, ~sum[7:0], ~sum[15:8]});
		rd(`HPM_OFS_RDCNT, 32'h8);
		rd(`HPM_OFS_ISTS, 32'h1);
		chk({31'h0, irq_o}, 32'h1);
		wr(`HPM_OFS_IEN, 32'h0);
		chk({31'h0, irq_o}, 32'h0);
		wr(`HPM_OFS_ISTS, 32'h1);
		rd(`HPM_OFS_ISTS, 32'h0);
		// Storage to host waits while only receive is enabled.
		wr(`HPM_OFS_SRC, 32'h80);
		wr(`HPM_OFS_DST, 32'h2C0);
		wr(`HPM_OFS_CNTFLG, 32'h0001_0006);
		repeat (20) @(posedge clk_sys_i);
		rd(`HPM_OFS_CNTFLG, 32'h0001_0006);
		wr(`HPM_OFS_CTRL, 32'h3);
		wait_done();
		chk(hpm_far_model_inst.hst_mem[48], 32'h5A00_2000);
		rd(`HPM_OFS_WRCNT, 32'h6);
		// Slow answers with a short burst limit and storage requests split at eight bytes.
		wr(`HPM_OFS_MAXBURST, 32'h2);
		wr(`HPM_OFS_MAXMEM, 32'h8);
		lim <= 16'h0008;
		far_slow <= 1'b1;
		firsts = 0;
		wr(`HPM_OFS_SRC, 32'h100);
		wr(`HPM_OFS_DST, 32'h40);
		wr(`HPM_OFS_CNTFLG, 32'h0002_0010);
		wait_done();
		chk(firsts, 32'h2);
		chk(hpm_far_model_inst.loc_mem[19], 32'hC0DE_0003);
		rd(`HPM_OFS_RDCNT, 32'h18);
		// Queue start of an odd-length storage copy leaves odd alignment behind.
		far_slow <= 1'b0;
		wr(`HPM_OFS_CSUM, 32'h0);
		wr(`HPM_OFS_ISTS, 32'h1);
		rd(`HPM_OFS_ISTS, 32'h0);
		@(posedge clk_sys_i);
		dq_src_i <= 32'h40;
		dq_dst_i <= 32'h80;
		dq_cntflg_i <= 32'h0007_0003;
		dq_start_i <= 1'b1;
		@(posedge clk_sys_i);
		dq_start_i <= 1'b0;
		wait_done();
		rd(`HPM_OFS_CSUM, 32'h8000_C0DE);
		rd(`HPM_OFS_ISTS, 32'h1);
		final_report();
	end
endmodule : test_host_packet_memory_dma
